/* File: common/arp_pkg.sv */
// Constants and types for the adaptive rate PHY control block
package arp_pkg;
  typedef logic [2:0] arp_cfg_type;
  typedef enum logic [1:0] {QSRC_PILOT, QSRC_PAYLOAD, QSRC_BOTH} arp_qsrc_type;
  typedef enum logic {DLY_IDLE, DLY_RUN} arp_dly_type;

  // Coding configurations, lowest rate first
  localparam int NUM_CFG = 6;
  localparam arp_cfg_type CFG_LOWEST = 3'h0;
  localparam arp_cfg_type CFG_MAX_GIG = 3'h5;
  localparam arp_cfg_type CFG_MAX_HUN = 3'h2;
  localparam arp_cfg_type CFG_MAX_HUN_100IF = 3'h1;
  localparam int RATE_GIG_MBPS [NUM_CFG] = '{249, 396, 547, 698, 849, 1000};
  localparam int RATE_HUN_MBPS [3] = '{49, 79, 109};
  localparam int LEVELS_GIG [NUM_CFG] = '{2, 4, 4, 8, 8, 16};
  localparam int LEVELS_HUN [3] = '{2, 4, 4};
  localparam int IF_GIG_MBPS = 1000;
  localparam int IF_HUN_MBPS = 100;

  // Lowest acceptable quality metric per configuration
  localparam logic [7:0] QUAL_MIN [NUM_CFG] =
    '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60};

  // Packet sizes
  localparam int LEN_W = 11;
  localparam logic [10:0] SHORT_PKT_LEN = 11'h040;
  localparam logic [10:0] LONG_PKT_LEN = 11'h5EE;

  // Combined transmit plus receive delay limits, microseconds
  localparam int DLY_LONG_US [NUM_CFG] = '{64, 51, 42, 44, 40, 25};
  localparam int DLY_SHORT_US [NUM_CFG] = '{13, 19, 18, 25, 25, 25};
  localparam int DLY_LONG_SIG_US [NUM_CFG] = '{51, 38, 29, 30, 27, 25};
  localparam int DLY_SHORT_SIG_US [NUM_CFG] = '{12, 18, 18, 25, 25, 25};
  localparam int CLK_MHZ = 50;
  localparam int DLY_W = 13;
  localparam logic [12:0] DLY_CNT_MAX = 13'h1FFF;
  localparam logic [12:0] DLY_CNT_ONE = 13'h0001;

  // Symbol rate and tolerance
  localparam int SYM_W = 29;
  localparam int SYM_HZ_GIG = 312_500_000;
  localparam int SYM_HZ_HUN = 62_500_000;
  localparam int SYM_TOL_PPM = 100;
  // Divide by the ppm scale first: the plain product overflows an int
  localparam int SYM_TOL_HZ_GIG = SYM_HZ_GIG / (1_000_000 / SYM_TOL_PPM);
  localparam int SYM_TOL_HZ_HUN = SYM_HZ_HUN / (1_000_000 / SYM_TOL_PPM);

  // Longest time, 3200 cycles, fits the 13-bit counter; every figure here is whole cycles anyway
  function automatic int us_to_cycles(input int us);
    return us * CLK_MHZ;
  endfunction : us_to_cycles
endpackage : arp_pkg

/* File: src/arp_rate_decide.sv */
// Picks the fastest coding configuration the measured quality supports
`timescale 1ns/1ps
module arp_rate_decide #(
  parameter int NCFG = arp_pkg::NUM_CFG
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Quality measurements
  input wire logic pilotQValid,
  input wire logic [7:0] pilotQ,
  input wire logic payloadQValid,
  input wire logic [7:0] payloadQ,
  input wire arp_pkg::arp_qsrc_type qualSrc,
  input wire arp_pkg::arp_cfg_type maxCfg,
  // Decision
  output arp_pkg::arp_cfg_type decision
);
  logic [7:0] pilotReg, pilotNext;
  logic [7:0] payloadReg, payloadNext;
  logic [7:0] metric;
  logic [NCFG-1:0] passes;
  arp_pkg::arp_cfg_type best;
  arp_pkg::arp_cfg_type decisionReg, decisionNext;

  always_comb begin
    pilotNext = pilotQValid ? pilotQ : pilotReg;
    payloadNext = payloadQValid ? payloadQ : payloadReg;
    // Either source alone, or the worse of the two
    unique case (qualSrc)
      arp_pkg::QSRC_PILOT: metric = pilotReg;
      arp_pkg::QSRC_PAYLOAD: metric = payloadReg;
      arp_pkg::QSRC_BOTH:
        metric = (pilotReg < payloadReg) ? pilotReg : payloadReg;
      default: metric = pilotReg;
    endcase
  end

  for (genvar i = 0; i < NCFG; i++) begin : g_cmp
    assign passes[i] = (metric >= arp_pkg::QUAL_MIN[i]) &&
                       (3'(i) <= maxCfg);
  end

  always_comb begin
    best = arp_pkg::CFG_LOWEST;
    for (int i = 0; i < NCFG; i++) begin
      if (passes[i]) begin
        best = 3'(i);
      end
    end
    decisionNext = best;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pilotReg <= 8'h00;
      payloadReg <= 8'h00;
      decisionReg <= arp_pkg::CFG_LOWEST;
    end else begin
      pilotReg <= pilotNext;
      payloadReg <= payloadNext;
      decisionReg <= decisionNext;
    end
  end

  assign decision = decisionReg;
endmodule : arp_rate_decide

/* File: src/arp_phy_control.sv */
// Rate adaptation, frame-aligned reconfiguration and delay monitoring
`timescale 1ns/1ps
module arp_phy_control #(
  parameter int NCFG = arp_pkg::NUM_CFG
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Variant and capability
  input wire logic gigVariant,
  input wire logic dataIfExposed,
  input wire logic ifCap1000,
  input wire logic lpiSupported,
  // Frame timing and received header
  input wire logic frameStart,
  input wire logic hdrValid,
  input wire arp_pkg::arp_cfg_type hdrNextCoding,
  input wire arp_pkg::arp_cfg_type hdrReqCoding,
  // Quality measurements
  input wire logic pilotQValid,
  input wire logic [7:0] pilotQ,
  input wire logic payloadQValid,
  input wire logic [7:0] payloadQ,
  input wire arp_pkg::arp_qsrc_type qualSrc,
  // Packet events
  input wire logic txPktStart,
  input wire logic txLenKnown,
  input wire logic [10:0] txPktLen,
  input wire logic rxPktStart,
  input wire logic rxLenSignalled,
  // Delay measurement
  input wire logic dlyStart,
  input wire logic dlyStop,
  input wire logic dlyLenSignalled,
  input wire logic [10:0] dlyLen,
  // Symbol rate measurement
  input wire logic symRateValid,
  input wire logic [28:0] txSymRateHz,
  input wire logic [28:0] rxSymRateHz,
  // Header fields and configuration
  output arp_pkg::arp_cfg_type reqCodingField,
  output arp_pkg::arp_cfg_type nextCodingField,
  output arp_pkg::arp_cfg_type rxDecodeCfg,
  output arp_pkg::arp_cfg_type txEncodeCfg,
  output logic lpiAdvertise,
  // Encapsulation and data interface
  output logic lenFieldValid,
  output logic [10:0] lenField,
  output logic cutThroughEn,
  output logic gigDataIf,
  // Status
  output logic delayViolation,
  output logic delayTargetMiss,
  output logic txSymRateOk,
  output logic rxSymRateOk
);
  arp_pkg::arp_cfg_type maxCfgReg, maxCfgNext;
  arp_pkg::arp_cfg_type decision;
  arp_pkg::arp_cfg_type reqReg, reqNext;
  arp_pkg::arp_cfg_type nextTxReg, nextTxNext;
  arp_pkg::arp_cfg_type rxCfgReg, rxCfgNext;
  arp_pkg::arp_cfg_type txCfgReg, txCfgNext;
  arp_pkg::arp_cfg_type pendCfgReg, pendCfgNext;
  logic pendValidReg, pendValidNext;
  logic lpiReg, lpiNext;
  logic gigIfReg, gigIfNext;
  logic lenValidReg, lenValidNext;
  logic [10:0] lenFieldReg, lenFieldNext;
  logic cutReg, cutNext;
  logic lineSlower;

  arp_rate_decide #(.NCFG(NCFG)) u_decide (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pilotQValid(pilotQValid),
    .pilotQ(pilotQ),
    .payloadQValid(payloadQValid),
    .payloadQ(payloadQ),
    .qualSrc(qualSrc),
    .maxCfg(maxCfgReg),
    .decision(decision)
  );

  // Configuration set, interface choice and frame switching
  always_comb begin
    if (gigVariant) begin
      maxCfgNext = arp_pkg::CFG_MAX_GIG;
    end else if (dataIfExposed && !ifCap1000) begin
      maxCfgNext = arp_pkg::CFG_MAX_HUN_100IF;
    end else begin
      maxCfgNext = arp_pkg::CFG_MAX_HUN;
    end
    // A 100 interface cuts delay when nothing faster is used
    gigIfNext = gigVariant ||
                (dataIfExposed && ifCap1000);
    lpiNext = lpiSupported;
    reqNext = frameStart ? decision : reqReg;
    nextTxNext = nextTxReg;
    if (hdrValid) begin
      nextTxNext = (hdrReqCoding > maxCfgReg) ? maxCfgReg : hdrReqCoding;
    end
    // Header arriving on the boundary itself belongs to the next frame
    pendCfgNext = hdrValid ? hdrNextCoding : pendCfgReg;
    pendValidNext = hdrValid || (pendValidReg && !frameStart);
    rxCfgNext = rxCfgReg;
    txCfgNext = txCfgReg;
    if (frameStart) begin
      txCfgNext = nextTxReg;
      if (pendValidReg) begin
        rxCfgNext = pendCfgReg;
      end
    end
  end

  // Length field and cut-through decision
  always_comb begin
    if (gigVariant) begin
      lineSlower = rxCfgReg < arp_pkg::CFG_MAX_GIG;
    end else begin
      lineSlower = gigIfReg || (rxCfgReg < arp_pkg::CFG_MAX_HUN);
    end
    lenValidNext = lenValidReg;
    lenFieldNext = lenFieldReg;
    if (txPktStart) begin
      lenValidNext = txLenKnown;
      lenFieldNext = txLenKnown ? txPktLen : 11'h000;
    end
    cutNext = cutReg;
    if (rxPktStart) begin
      cutNext = rxLenSignalled && lineSlower;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      maxCfgReg <= arp_pkg::CFG_LOWEST;
      gigIfReg <= 1'b0;
      lpiReg <= 1'b0;
      reqReg <= arp_pkg::CFG_LOWEST;
      nextTxReg <= arp_pkg::CFG_LOWEST;
      pendCfgReg <= arp_pkg::CFG_LOWEST;
      pendValidReg <= 1'b0;
      rxCfgReg <= arp_pkg::CFG_LOWEST;
      txCfgReg <= arp_pkg::CFG_LOWEST;
      lenValidReg <= 1'b0;
      lenFieldReg <= 11'h000;
      cutReg <= 1'b0;
    end else begin
      maxCfgReg <= maxCfgNext;
      gigIfReg <= gigIfNext;
      lpiReg <= lpiNext;
      reqReg <= reqNext;
      nextTxReg <= nextTxNext;
      pendCfgReg <= pendCfgNext;
      pendValidReg <= pendValidNext;
      rxCfgReg <= rxCfgNext;
      txCfgReg <= txCfgNext;
      lenValidReg <= lenValidNext;
      lenFieldReg <= lenFieldNext;
      cutReg <= cutNext;
    end
  end

  // Delay monitor; limits exist only for the gigabit variant
  arp_pkg::arp_dly_type dlyStateReg, dlyStateNext;
  logic [12:0] dlyCntReg, dlyCntNext;
  logic dlyShortReg, dlyShortNext;
  logic dlySigReg, dlySigNext;
  logic violReg, violNext;
  logic missReg, missNext;
  int limitCyc;
  int targetCyc;

  always_comb begin
    if (dlyShortReg) begin
      limitCyc = arp_pkg::us_to_cycles(
        arp_pkg::DLY_SHORT_US[rxCfgReg]);
      targetCyc = arp_pkg::us_to_cycles(
        arp_pkg::DLY_SHORT_SIG_US[rxCfgReg]);
    end else begin
      limitCyc = arp_pkg::us_to_cycles(
        arp_pkg::DLY_LONG_US[rxCfgReg]);
      targetCyc = arp_pkg::us_to_cycles(
        arp_pkg::DLY_LONG_SIG_US[rxCfgReg]);
    end
    dlyStateNext = dlyStateReg;
    dlyCntNext = dlyCntReg;
    dlyShortNext = dlyShortReg;
    dlySigNext = dlySigReg;
    violNext = violReg;
    missNext = missReg;
    unique case (dlyStateReg)
      arp_pkg::DLY_IDLE: begin
        if (dlyStart) begin
          dlyStateNext = arp_pkg::DLY_RUN;
          dlyCntNext = 13'h0000;
          dlyShortNext = dlyLen <= arp_pkg::SHORT_PKT_LEN;
          dlySigNext = dlyLenSignalled;
          violNext = 1'b0;
          missNext = 1'b0;
        end
      end
      arp_pkg::DLY_RUN: begin
        if (dlyCntReg != arp_pkg::DLY_CNT_MAX) begin
          dlyCntNext = dlyCntReg + arp_pkg::DLY_CNT_ONE;
        end
        // Exceeding is flagged one cycle after it happens, stop or not
        if (gigVariant && 32'(dlyCntReg) > limitCyc) begin
          violNext = 1'b1;
        end
        if (gigVariant && dlySigReg && 32'(dlyCntReg) > targetCyc) begin
          missNext = 1'b1;
        end
        if (dlyStop) begin
          dlyStateNext = arp_pkg::DLY_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dlyStateReg <= arp_pkg::DLY_IDLE;
      dlyCntReg <= 13'h0000;
      dlyShortReg <= 1'b0;
      dlySigReg <= 1'b0;
      violReg <= 1'b0;
      missReg <= 1'b0;
    end else begin
      dlyStateReg <= dlyStateNext;
      dlyCntReg <= dlyCntNext;
      dlyShortReg <= dlyShortNext;
      dlySigReg <= dlySigNext;
      violReg <= violNext;
      missReg <= missNext;
    end
  end

  // Symbol rate window checks
  logic txOkReg, txOkNext;
  logic rxOkReg, rxOkNext;
  int nomHz;
  int tolHz;

  always_comb begin
    nomHz = gigVariant ? arp_pkg::SYM_HZ_GIG : arp_pkg::SYM_HZ_HUN;
    tolHz = gigVariant ? arp_pkg::SYM_TOL_HZ_GIG : arp_pkg::SYM_TOL_HZ_HUN;
    txOkNext = txOkReg;
    rxOkNext = rxOkReg;
    if (symRateValid) begin
      txOkNext = (32'(txSymRateHz) >= nomHz - tolHz) &&
                 (32'(txSymRateHz) <= nomHz + tolHz);
      rxOkNext = (32'(rxSymRateHz) >= nomHz - tolHz) &&
                 (32'(rxSymRateHz) <= nomHz + tolHz);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txOkReg <= 1'b0;
      rxOkReg <= 1'b0;
    end else begin
      txOkReg <= txOkNext;
      rxOkReg <= rxOkNext;
    end
  end

  assign reqCodingField = reqReg;
  assign nextCodingField = nextTxReg;
  assign rxDecodeCfg = rxCfgReg;
  assign txEncodeCfg = txCfgReg;
  assign lpiAdvertise = lpiReg;
  assign lenFieldValid = lenValidReg;
  assign lenField = lenFieldReg;
  assign cutThroughEn = cutReg;
  assign gigDataIf = gigIfReg;
  assign delayViolation = violReg;
  assign delayTargetMiss = missReg;
  assign txSymRateOk = txOkReg;
  assign rxSymRateOk = rxOkReg;

  property p_rx_cfg_frame;
    @(posedge clk_sys) disable iff (!rst_n)
    !frameStart |=> $stable(rxDecodeCfg) && $stable(txEncodeCfg);
  endproperty
  a_rx_cfg_frame: assert property (p_rx_cfg_frame)
    else $error("configuration changed inside a frame");

  // Checker copy of the latest announcement; frames are far too long
  // to spell the gap between header and boundary as a repetition
  arp_pkg::arp_cfg_type annCfgReg, annCfgNext;
  logic annSeenReg, annSeenNext;

  always_comb begin
    annCfgNext = hdrValid ? hdrNextCoding : annCfgReg;
    annSeenNext = hdrValid || (annSeenReg && !frameStart);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      annCfgReg <= arp_pkg::CFG_LOWEST;
      annSeenReg <= 1'b0;
    end else begin
      annCfgReg <= annCfgNext;
      annSeenReg <= annSeenNext;
    end
  end

  property p_rx_follows;
    @(posedge clk_sys) disable iff (!rst_n)
    frameStart && annSeenReg |=> rxDecodeCfg == $past(annCfgReg);
  endproperty
  a_rx_follows: assert property (p_rx_follows)
    else $error("decoder did not take announced configuration");

  property p_req_range;
    @(posedge clk_sys) disable iff (!rst_n)
    frameStart |=> reqCodingField <= $past(maxCfgReg, 2);
  endproperty
  a_req_range: assert property (p_req_range)
    else $error("requested configuration outside supported set");

  property p_hun_set;
    @(posedge clk_sys) disable iff (!rst_n)
    !gigVariant && !dataIfExposed ##1 !gigVariant && !dataIfExposed
      |=> maxCfgReg == arp_pkg::CFG_MAX_HUN;
  endproperty
  a_hun_set: assert property (p_hun_set)
    else $error("hundred variant configuration set wrong");

  property p_len_field;
    @(posedge clk_sys) disable iff (!rst_n)
    txPktStart && txLenKnown
      |=> lenFieldValid && lenField == $past(txPktLen);
  endproperty
  a_len_field: assert property (p_len_field)
    else $error("known length missing from block control");

  property p_cut;
    @(posedge clk_sys) disable iff (!rst_n)
    rxPktStart && !rxLenSignalled |=> !cutThroughEn;
  endproperty
  a_cut: assert property (p_cut)
    else $error("cut-through without signalled length");

  property p_dly_viol;
    @(posedge clk_sys) disable iff (!rst_n)
    dlyStateReg == arp_pkg::DLY_RUN && gigVariant &&
      32'(dlyCntReg) > limitCyc |=> delayViolation;
  endproperty
  a_dly_viol: assert property (p_dly_viol)
    else $error("delay overrun not flagged");

  property p_rx_sym;
    @(posedge clk_sys) disable iff (!rst_n)
    symRateValid && !gigVariant &&
      32'(rxSymRateHz) >= arp_pkg::SYM_HZ_HUN - arp_pkg::SYM_TOL_HZ_HUN &&
      32'(rxSymRateHz) <= arp_pkg::SYM_HZ_HUN + arp_pkg::SYM_TOL_HZ_HUN
      |=> rxSymRateOk;
  endproperty
  a_rx_sym: assert property (p_rx_sym)
    else $error("in-window receive symbol rate rejected");

  property p_lpi;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(lpiSupported) |=> lpiAdvertise ##1 (lpiAdvertise || !lpiSupported);
  endproperty
  a_lpi: assert property (p_lpi)
    else $error("low power idle support not advertised");
endmodule : arp_phy_control

/* File: test/arp_remote_model.sv */
// Far end link partner: frames, header fields and request handling
`timescale 1ns/1ps
module arp_remote_model #(
  parameter int FRAME_LEN = 40,
  parameter int HDR_AT = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Our request and test controls
  input wire arp_pkg::arp_cfg_type reqIn,
  input wire arp_pkg::arp_cfg_type farReq,
  input wire logic forceEn,
  input wire arp_pkg::arp_cfg_type forceCfg,
  // Toward the block
  output logic frameStart,
  output logic hdrValid,
  output arp_pkg::arp_cfg_type hdrNextCoding,
  output arp_pkg::arp_cfg_type hdrReqCoding
);
  int cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      frameStart <= 1'h0;
      hdrValid <= 1'h0;
      hdrNextCoding <= 3'h0;
      hdrReqCoding <= 3'h0;
    end else begin
      cnt <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
      frameStart <= (cnt == FRAME_LEN - 1);
      hdrValid <= (cnt == HDR_AT);
      if (cnt == HDR_AT) begin
        // Honour the request unless told to override it
        hdrNextCoding <= forceEn ? forceCfg : reqIn;
        hdrReqCoding <= farReq;
      end else begin
        // Fields are stale outside the header: keep them moving
        hdrNextCoding <= ~hdrNextCoding;
        hdrReqCoding <= ~hdrReqCoding;
      end
    end
  end
endmodule : arp_remote_model

/* File: test/tb_top.sv */
// Self-checking bench for the adaptive rate PHY control block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'h0, rst_n = 1'h0;
  logic gigVariant = 1'h1, dataIfExposed = 1'h0, ifCap1000 = 1'h0;
  logic lpiSupported = 1'h0, frameStart, hdrValid;
  arp_pkg::arp_cfg_type hdrNextCoding, hdrReqCoding, forceCfg = 3'h0;
  arp_pkg::arp_cfg_type reqCodingField, nextCodingField;
  arp_pkg::arp_cfg_type rxDecodeCfg, txEncodeCfg;
  logic forceEn = 1'h0, pilotQValid = 1'h0, payloadQValid = 1'h0;
  logic [7:0] pilotQ = 8'h00, payloadQ = 8'h00;
  arp_pkg::arp_qsrc_type qualSrc = arp_pkg::QSRC_PILOT;
  logic txPktStart = 1'h0, txLenKnown = 1'h0, rxPktStart = 1'h0;
  logic rxLenSignalled = 1'h0, dlyStart = 1'h0, dlyStop = 1'h0;
  logic dlyLenSignalled = 1'h0, symRateValid = 1'h0;
  logic [10:0] txPktLen = 11'h000, dlyLen = 11'h000;
  logic [28:0] txSymRateHz = 29'h0, rxSymRateHz = 29'h0;
  logic lpiAdvertise, lenFieldValid, cutThroughEn, gigDataIf;
  logic [10:0] lenField;
  logic delayViolation, delayTargetMiss, txSymRateOk, rxSymRateOk;
  int fail_count = 0, checks_done = 0;
  // Rate decision table: variant, exposure, quality, expected results
  localparam logic GV [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  localparam logic EX [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  localparam logic CP [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  localparam arp_pkg::arp_qsrc_type SR [7] = '{arp_pkg::QSRC_PILOT,
    arp_pkg::QSRC_PAYLOAD, arp_pkg::QSRC_BOTH, arp_pkg::QSRC_PILOT,
    arp_pkg::QSRC_PILOT, arp_pkg::QSRC_PILOT, arp_pkg::QSRC_PILOT};
  localparam logic [7:0] PQ [7] = '{8'h35, 8'h00, 8'h45, 8'h0F, 8'h60,
    8'h60, 8'h60};
  localparam logic [7:0] YQ [7] = '{8'h00, 8'h60, 8'h25, 8'h00, 8'h00,
    8'h00, 8'h00};
  localparam logic [2:0] DEC [7] = '{3'h2, 3'h5, 3'h1, 3'h0, 3'h2, 3'h1,
    3'h2};
  localparam logic [2:0] MX [7] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h2, 3'h1,
    3'h2};
  // Two means the interface choice is left open for that row
  localparam logic [1:0] GD [7] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0,
    2'h1};

  always #10 clk_sys = ~clk_sys;

  arp_phy_control uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .gigVariant(gigVariant), .dataIfExposed(dataIfExposed),
    .ifCap1000(ifCap1000), .lpiSupported(lpiSupported),
    .frameStart(frameStart), .hdrValid(hdrValid),
    .hdrNextCoding(hdrNextCoding), .hdrReqCoding(hdrReqCoding),
    .pilotQValid(pilotQValid), .pilotQ(pilotQ),
    .payloadQValid(payloadQValid), .payloadQ(payloadQ),
    .qualSrc(qualSrc), .txPktStart(txPktStart), .txLenKnown(txLenKnown),
    .txPktLen(txPktLen), .rxPktStart(rxPktStart),
    .rxLenSignalled(rxLenSignalled), .dlyStart(dlyStart),
    .dlyStop(dlyStop), .dlyLenSignalled(dlyLenSignalled),
    .dlyLen(dlyLen), .symRateValid(symRateValid),
    .txSymRateHz(txSymRateHz), .rxSymRateHz(rxSymRateHz),
    .reqCodingField(reqCodingField), .nextCodingField(nextCodingField),
    .rxDecodeCfg(rxDecodeCfg), .txEncodeCfg(txEncodeCfg),
    .lpiAdvertise(lpiAdvertise), .lenFieldValid(lenFieldValid),
    .lenField(lenField), .cutThroughEn(cutThroughEn),
    .gigDataIf(gigDataIf), .delayViolation(delayViolation),
    .delayTargetMiss(delayTargetMiss), .txSymRateOk(txSymRateOk),
    .rxSymRateOk(rxSymRateOk));

  arp_remote_model far (.clk_sys(clk_sys), .rst_n(rst_n),
    .reqIn(reqCodingField), .farReq(3'h7), .forceEn(forceEn),
    .forceCfg(forceCfg), .frameStart(frameStart), .hdrValid(hdrValid),
    .hdrNextCoding(hdrNextCoding), .hdrReqCoding(hdrReqCoding));

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task conclude;
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Waits for a header (sel high) or a frame start; bounded
  task waitSig(input logic sel);
    int n;
    n = 0;
    @(posedge clk_sys);
    while ((sel ? hdrValid : frameStart) !== 1'h1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100) fail_count++;
    #1;
  endtask : waitSig

  // Runs one delay measurement and checks when the chosen flag rises
  task dly(input logic [10:0] len, input logic sg, input int lim,
           input logic miss);
    @(posedge clk_sys);
    dlyLen <= len;
    dlyLenSignalled <= sg;
    dlyStart <= 1'h1;
    @(posedge clk_sys);
    dlyStart <= 1'h0;
    tick(lim);
    check("flag at limit", miss ? delayTargetMiss : delayViolation, 0);
    tick(4);
    check("flag past limit", miss ? delayTargetMiss : delayViolation, 1);
    check("other flag", miss ? delayViolation : delayTargetMiss, 0);
    @(posedge clk_sys);
    dlyStop <= 1'h1;
    @(posedge clk_sys);
    dlyStop <= 1'h0;
  endtask : dly

  task cut(input logic sg, input logic exp);
    @(posedge clk_sys);
    rxLenSignalled <= sg;
    rxPktStart <= 1'h1;
    @(posedge clk_sys);
    rxPktStart <= 1'h0;
    #1;
    check("cutThroughEn", cutThroughEn, exp);
  endtask : cut

  initial begin
    int hz;
    tick(4);
    check("rxDecodeCfg in reset", rxDecodeCfg, 0);
    check("reqCodingField in reset", reqCodingField, 0);
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    lpiSupported <= 1'h1;
    tick(2);
    check("lpiAdvertise", lpiAdvertise, 1);
    lpiSupported <= 1'h0;
    tick(2);
    check("lpiAdvertise", lpiAdvertise, 0);
    // Back to back packets, known then unknown length
    @(posedge clk_sys);
    txPktStart <= 1'h1;
    txLenKnown <= 1'h1;
    txPktLen <= arp_pkg::LONG_PKT_LEN;
    @(posedge clk_sys);
    txLenKnown <= 1'h0;
    txPktLen <= 11'h123;
    #1;
    check("lenFieldValid", lenFieldValid, 1);
    check("lenField", lenField, 32'h5EE);
    @(posedge clk_sys);
    txPktStart <= 1'h0;
    #1;
    check("lenFieldValid", lenFieldValid, 0);
    check("lenField", lenField, 0);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      gigVariant <= GV[i];
      dataIfExposed <= EX[i];
      ifCap1000 <= CP[i];
      qualSrc <= SR[i];
      pilotQ <= PQ[i];
      payloadQ <= YQ[i];
      pilotQValid <= 1'h1;
      payloadQValid <= 1'h1;
      @(posedge clk_sys);
      pilotQValid <= 1'h0;
      payloadQValid <= 1'h0;
      repeat (3) waitSig(1'h0);
      check("reqCodingField", reqCodingField, DEC[i]);
      check("rxDecodeCfg", rxDecodeCfg, DEC[i]);
      check("nextCodingField", nextCodingField, MX[i]);
      check("txEncodeCfg", txEncodeCfg, MX[i]);
      if (GD[i] != 2'h2) check("gigDataIf", gigDataIf, GD[i][0]);
    end
    // Switch must wait for the frame boundary
    @(posedge clk_sys);
    gigVariant <= 1'h1;
    forceEn <= 1'h1;
    forceCfg <= 3'h4;
    waitSig(1'h1);
    tick(2);
    check("rxDecodeCfg before boundary", rxDecodeCfg, 2);
    waitSig(1'h0);
    check("rxDecodeCfg at boundary", rxDecodeCfg, 4);
    check("gigDataIf", gigDataIf, 1);
    dly(arp_pkg::LONG_PKT_LEN, 1'h0,
        arp_pkg::DLY_LONG_US[4] * arp_pkg::CLK_MHZ, 1'h0);
    dly(arp_pkg::SHORT_PKT_LEN, 1'h0,
        arp_pkg::DLY_SHORT_US[4] * arp_pkg::CLK_MHZ, 1'h0);
    dly(arp_pkg::LONG_PKT_LEN, 1'h1,
        arp_pkg::DLY_LONG_SIG_US[4] * arp_pkg::CLK_MHZ, 1'h1);
    cut(1'h1, 1'h1);
    cut(1'h0, 1'h0);
    // At the top rate the line is no slower than the interface
    forceCfg <= 3'h5;
    // A header already under way may still carry the old value
    repeat (2) waitSig(1'h0);
    cut(1'h1, 1'h0);
    // Edges of the 100 ppm window, both variants
    for (int j = 0; j < 4; j++) begin
      hz = j[1] ? arp_pkg::SYM_HZ_GIG : arp_pkg::SYM_HZ_HUN;
      @(posedge clk_sys);
      gigVariant <= j[1];
      txSymRateHz <= 29'(hz + hz / 10000 + j[0]);
      rxSymRateHz <= 29'(hz - hz / 10000 - (1 - j[0]));
      symRateValid <= 1'h1;
      @(posedge clk_sys);
      symRateValid <= 1'h0;
      #1;
      check("txSymRateOk", txSymRateOk, !j[0]);
      check("rxSymRateOk", rxSymRateOk, j[0]);
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
endmodule : tb_top
